// [sbi_core.sv]
/*
  System bus interface of a 32-bit processor: masters transfers for
  the core, arbitrates, snoops alternate masters, catches mode straps.
  Assumes all pins come from outside the sys_clk domain; the core side
  is synchronous logic on sys_clk.
*/
// What this block does
// - Drive 32-bit address on mastered transfers.
// - Data bus 32 bits per transfer.
// - Drive two-bit transfer kind field.
// - Byte lanes from size and address.
// - Lock asserted on read-modify-write transfers.
// - Lock end only on final locked transfer.
// - Start strobe marks each transfer.
// - Active held for whole transfer.
// - Slave cache inhibit stops caching data.
// - Request bus, arbiter grants it.
// - Owner asserts bus busy.
// - Snoop select chooses; memory suppressed on intervention.
// - Sample address while another master owns.
// - Address of first item, not acknowledge.
// - Cache disable at reset picks multiplexed mode.
// - Cache disable outside reset turns caches off.
// - Latch mode captures data on latch clock.
// - Reset output during software reset.
// - Autovector request during acknowledge transfer.
// - Kind codes normal, move, alternate, acknowledge.
// - Snoop only normal and block-move kinds.
// - Read high, write low.
`include "sbi_regs.svh"
`default_nettype none
module sbi_core
  import sbi_pkg::*;
#(
  parameter int SYNC_N = 3
)(
  // Clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rstn,
  // Core request port
  input  wire logic   req_valid,
  output logic        req_ready,
  input  wire sbi_req_t req,
  // Core answer port, one pulse per beat
  output logic        ans_valid,
  output sbi_ans_t    ans,
  // Snoop notice and core decision
  output logic        snoop_valid,
  output sbi_snoop_t  snoop,
  input  wire logic   snoop_intervene,
  // Core control and status
  input  wire logic   soft_reset,
  output logic        caches_off,
  output logic        mux_mode,
  output logic        latch_mode,
  output logic        irq_waiting,
  // Bus pins: levels in, levels out, enables low while driving
  input  wire sbi_pin_in_t pin_in,
  output sbi_pin_out_t pin_out,
  output logic        addr_oe_n,
  output logic        data_oe_n,
  output logic        attr_oe_n,
  output logic        begin_oe_n,
  output logic        owned_oe_n,
  // Plain outputs
  output logic        bus_req,
  output logic        lock,
  output logic        rmw_last,
  output logic        xfer_active,
  output logic        mem_suppress,
  output logic        reset_out
);
  localparam int PW = $bits(sbi_pin_in_t);

  // Refuse any filter length other than three, the length of the agree-of-two scheme
  if (SYNC_N != 3)
  begin : g_bad
    $error("sbi_core: SYNC_N must be 3");
  end

  // Three-stage pin filter; only stage two reads stage one
  logic [PW-1:0] s1_q, s2_q, s3_q, filt_q;
  sbi_pin_in_t   f;
  assign f = sbi_pin_in_t'(filt_q);

  // Filter keeps sampling in reset so straps are valid at release
  for (genvar i = 0; i < PW; i++)
  begin : g_sync
    always_ff @(posedge sys_clk)
    begin
      s1_q[i] <= pin_in[i];
      s2_q[i] <= s1_q[i];
      s3_q[i] <= s2_q[i];
      // A change counts once two and three agree
      if (!rstn || s2_q[i] == s3_q[i])
        filt_q[i] <= s3_q[i];
    end
  end

  // Byte lanes from size and low address bits, lane 0 is bits 31:24
  function automatic logic [3:0] lanes_of(input logic [1:0] sz,
                                          input logic [1:0] a);
    logic [3:0] m;
    m = `SBI_LANES_NONE;
    unique case (sz)
      `SBI_SIZE_BYTE: m = 4'(`SBI_LANE_ONE << a);
      `SBI_SIZE_WORD: m = 4'(`SBI_LANE_TWO << {a[1], 1'b0});
      default:        m = `SBI_LANES_ALL;
    endcase
    return m;
  endfunction

  // Edge detection on the filtered terminations, latch clock and start strobe
  logic ack_prev_q, err_prev_q, dle_prev_q, beg_prev_q;
  logic ack_rise, err_rise, dle_rise, beg_rise;
  assign ack_rise = f.xfer_ack & ~ack_prev_q;
  assign err_rise = f.xfer_err_ack & ~err_prev_q;
  assign dle_rise = f.read_latch_clk & ~dle_prev_q;
  assign beg_rise = f.xfer_begin & ~beg_prev_q;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      ack_prev_q <= 1'b0;
      err_prev_q <= 1'b0;
      dle_prev_q <= 1'b0;
      beg_prev_q <= 1'b0;
    end
    else
    begin
      ack_prev_q <= f.xfer_ack;
      err_prev_q <= f.xfer_err_ack;
      dle_prev_q <= f.read_latch_clk;
      beg_prev_q <= f.xfer_begin;
    end
  end

  // Straps are caught while reset is held; last value at release
  logic mux_q, latch_q;
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      mux_q   <= f.cache_off;
      latch_q <= f.xlate_off;
    end
  end
  assign mux_mode   = mux_q;
  assign latch_mode = latch_q;

  // Dynamic cache disable only outside reset
  logic cache_off_q;
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      cache_off_q <= 1'b0;
    else
      cache_off_q <= f.cache_off;
  end
  assign caches_off = cache_off_q;

  // Reset output follows the core's software reset
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      reset_out <= 1'b0;
    else
      reset_out <= soft_reset;
  end

  // Pending interrupt when any level is presented
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      irq_waiting <= 1'b0;
    else
      irq_waiting <= (f.irq_level != `SBI_IRQ_NONE);
  end

  // Read data latched on every rising latch clock edge; answers use it in latch mode
  logic [31:0] dle_data_q;
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      dle_data_q <= '0;
    else if (dle_rise)
      dle_data_q <= f.data;
  end

  // Master controller
  sbi_state_t st_q;
  sbi_req_t   cur_q;
  logic [1:0] beat_q;
  logic       own_q;
  logic       burst;
  logic       term;
  logic       last_beat;
  assign burst = (cur_q.size == `SBI_SIZE_LINE);
  assign term  = (st_q == S_WAIT) && (ack_rise || err_rise);
  // A refused burst or an error ends after this beat
  assign last_beat = err_rise || !burst || f.burst_refuse ||
                     (beat_q == `SBI_LAST_BEAT);
  assign req_ready = (st_q == S_IDLE);

  // State sequencing; the bus is taken only when free and granted
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      st_q <= S_IDLE;
    else
      unique case (st_q)
        S_IDLE:
          if (req_valid)
            st_q <= S_ARB;
        S_ARB:
          if (f.bus_grant && !f.bus_owned)
            st_q <= S_START;
        S_START:
          st_q <= S_WAIT;
        S_WAIT:
          if (term && last_beat)
            st_q <= S_IDLE;
      endcase
  end

  // Request held unchanged from acceptance to termination
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      cur_q <= '0;
    else if (req_valid && req_ready)
      cur_q <= req;
  end

  // Beat counter for line bursts
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || st_q == S_START)
      beat_q <= '0;
    else if (term)
      beat_q <= 2'(beat_q + 2'h1);
  end

  // Ownership from start strobe to final termination
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      own_q <= 1'b0;
    else if (st_q == S_ARB && f.bus_grant && !f.bus_owned)
      own_q <= 1'b1;
    else if (term && last_beat)
      own_q <= 1'b0;
  end

  // Bus request while waiting for mastership
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      bus_req <= 1'b0;
    else
      bus_req <= (st_q == S_IDLE && req_valid) ||
                 (st_q == S_ARB && !(f.bus_grant && !f.bus_owned));
  end

  // Pin values; acknowledge transfers carry no address
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      pin_out <= '0;
    else
    begin
      pin_out.addr <= (cur_q.kind == `SBI_KIND_ACK) ? '0 :
                      cur_q.addr;
      pin_out.data <= cur_q.wdata;
      pin_out.kind <= cur_q.kind;
      pin_out.rw   <= cur_q.rw;
      pin_out.size <= cur_q.size;
      pin_out.xfer_begin <= (st_q == S_ARB) &&
                            f.bus_grant && !f.bus_owned;
      pin_out.bus_owned  <= own_q;
    end
  end

  // Next level of the active output; lock follows it so that lock is
  // already up in the start cycle instead of one cycle behind it
  logic act_d;
  assign act_d = (st_q == S_ARB && f.bus_grant && !f.bus_owned) ||
                 (st_q == S_START) ||
                 (st_q == S_WAIT && !(term && last_beat));

  // Active level and lock attributes across the transfer
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      xfer_active <= 1'b0;
      lock        <= 1'b0;
      rmw_last    <= 1'b0;
    end
    else
    begin
      xfer_active <= act_d;
      lock     <= act_d && cur_q.lock;
      rmw_last <= act_d && cur_q.lock && cur_q.lock_last;
    end
  end

  // Enables; in multiplexed mode the data phase follows the address
  assign addr_oe_n  = !(own_q && (!mux_q || st_q == S_START));
  assign data_oe_n  = !(own_q && !cur_q.rw &&
                        (!mux_q || st_q == S_WAIT));
  assign attr_oe_n  = !own_q;
  assign begin_oe_n = !own_q;
  assign owned_oe_n = !own_q;

  // Answer to the core, one pulse per terminated beat
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      ans_valid <= 1'b0;
      ans       <= '0;
    end
    else
    begin
      ans_valid <= term;
      if (term)
      begin
        ans.rdata   <= latch_q ? dle_data_q : f.data;
        ans.lanes   <= lanes_of(cur_q.size, cur_q.addr[1:0]);
        ans.err     <= err_rise;
        ans.nocache <= f.slave_nocache || cache_off_q;
        ans.burst_refused <= burst && f.burst_refuse;
        ans.auto_vec <= (cur_q.kind == `SBI_KIND_ACK) &&
                        f.auto_vector_req;
        ans.last    <= last_beat;
      end
    end
  end

  // Snooping of alternate master starts; bus rate is an other-side
  // matter, this logic only needs the start edge
  logic snoop_hit;
  assign snoop_hit = !own_q && beg_rise &&
    (f.snoop_sel != `SBI_SNOOP_NONE) &&
    (f.kind == `SBI_KIND_NORMAL || f.kind == `SBI_KIND_MOVE);

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      snoop_valid <= 1'b0;
      snoop       <= '0;
    end
    else
    begin
      snoop_valid <= snoop_hit;
      if (snoop_hit)
      begin
        snoop.addr <= f.addr;
        snoop.rw   <= f.rw;
        snoop.size <= f.size;
        snoop.op   <= f.snoop_sel;
      end
    end
  end

  // Memory suppression from intervention until the access ends;
  // a new intervention wins over the ending
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      mem_suppress <= 1'b0;
    else if (snoop_valid && snoop_intervene)
      mem_suppress <= 1'b1;
    else if (ack_rise || err_rise)
      mem_suppress <= 1'b0;
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence start_seq;
    pin_out.xfer_begin && xfer_active;
  endsequence

  a_start_one: assert property (
    pin_out.xfer_begin |=> !pin_out.xfer_begin)
    else $error("start strobe longer than one cycle");
  a_active_hold: assert property (
    start_seq |=> xfer_active [*2])
    else $error("active dropped early");
  a_start_own: assert property (
    start_seq |-> ##1 own_q)
    else $error("start without ownership");
  a_attr_stable: assert property (
    (st_q == S_WAIT && !term) |=> $stable(pin_out.addr) &&
      $stable(pin_out.kind) && $stable(pin_out.size))
    else $error("attributes moved mid transfer");
  a_lock_end: assert property (
    rmw_last |-> lock)
    else $error("lock end without lock");
  a_term_answer: assert property (
    term |=> ans_valid)
    else $error("termination gave no answer");
  a_ack_noaddr: assert property (
    (own_q && cur_q.kind == `SBI_KIND_ACK && st_q == S_WAIT)
      |-> pin_out.addr == '0)
    else $error("address driven on acknowledge");
  a_snoop_kind: assert property (
    snoop_hit |=> snoop_valid && snoop.op != `SBI_SNOOP_NONE)
    else $error("snoop taken badly");
  a_refuse_end: assert property (
    (term && f.burst_refuse) |=> st_q == S_IDLE)
    else $error("refused burst went on");
  a_reset_out: assert property (
    soft_reset |=> reset_out)
    else $error("reset output missing");
endmodule
`default_nettype wire

// [sbi_far_model.sv]
/*
  Far side of the system bus: arbiter, one slave and one alternate
  master, all behavioural and clocked on sys_clk.
  Assumes the bench steers the error, refuse, no-cache and alternate
  master controls by non-blocking assignment at the rising edge.
*/
`default_nettype none
module sbi_far_model
  import sbi_pkg::*;
#(
  parameter logic [31:0] RD_BASE  = 32'h5A00_0000,
  parameter logic [31:0] ALT_ADDR = 32'h00C0_FFE0
)(
  // Clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rstn,
  // Levels from the processor side
  input  wire logic   bus_req,
  input  wire logic   xfer_active,
  input  wire sbi_pin_out_t pin_out,
  input  wire logic   addr_oe_n,
  input  wire logic   data_oe_n,
  input  wire logic   attr_oe_n,
  input  wire logic   begin_oe_n,
  input  wire logic   owned_oe_n,
  // Bench controls
  input  wire logic   err_on,
  input  wire logic   refuse_on,
  input  wire logic   nc_on,
  input  wire logic   cache_off,
  input  wire logic   alt_go,
  input  wire logic [1:0] alt_kind,
  input  wire logic [1:0] alt_sel,
  // Resolved wire levels
  output sbi_pin_in_t pin_in
);
  sbi_pin_in_t m;       // Levels this side drives
  logic [7:0]  scnt;    // Cycles since the processor took the bus
  logic [1:0]  beat;    // Beat index within a transfer
  logic [4:0]  acnt;    // Alternate master cycle count
  logic        win;     // Slave answer window
  // Three cycles high, five low: the pin filter needs both
  assign win = xfer_active && scnt[2:0] >= 3'h5;
  // Slave and alternate master sequencing
  always_ff @(posedge sys_clk)
    if (!rstn)
    begin
      scnt <= '0;
      beat <= '0;
      acnt <= '0;
    end
    else
    begin
      scnt <= xfer_active ? scnt + 8'h01 : 8'h00;
      beat <= !xfer_active ? 2'h0 : beat + 2'(scnt[2:0] == 3'h7);
      acnt <= !alt_go ? 5'h00 : acnt + 5'(acnt != 5'h1F);
    end
  // Registered far-side levels; released address, data and kind lines toggle, rw and size hold
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      m <= '0;
    else
    begin
      m.addr <= alt_go ? ALT_ADDR : ~m.addr;
      m.data <= win ? RD_BASE + 32'(beat) : ~m.data;
      m.kind <= alt_go ? alt_kind : ~m.kind;
      m.rw   <= 1'b1;
      m.xfer_begin <= alt_go && acnt >= 5'h01 && acnt <= 5'h03;
      m.xfer_ack <= (win && !err_on)
                    || (acnt >= 5'h0C && acnt <= 5'h0E);
      m.xfer_err_ack <= win && err_on;
      m.slave_nocache <= win && nc_on;
      m.burst_refuse <= win && refuse_on;
      m.snoop_sel <= alt_go ? alt_sel : 2'h0;
      m.bus_grant <= bus_req && !alt_go;
      m.bus_owned <= alt_go;
    end
    // Mode strap must reach the pin while reset is held
    m.cache_off <= cache_off;
  end
  // Wire level: whoever has its enable low wins
  always_comb
  begin
    pin_in = m;
    if (!addr_oe_n) pin_in.addr = pin_out.addr;
    if (!data_oe_n) pin_in.data = pin_out.data;
    if (!attr_oe_n) pin_in.kind = pin_out.kind;
    if (!attr_oe_n) pin_in.rw = pin_out.rw;
    if (!attr_oe_n) pin_in.size = pin_out.size;
    if (!begin_oe_n) pin_in.xfer_begin = pin_out.xfer_begin;
    if (!owned_oe_n) pin_in.bus_owned = pin_out.bus_owned;
  end
endmodule
`default_nettype wire

// [sbi_pkg.sv]
/*
  Types of the system bus interface: pin bundles, core request and
  answer, snoop notice and controller states.
  Assumes sbi_regs.svh is on the include path.
*/
`default_nettype none
package sbi_pkg;
  // Levels arriving on the pins, before filtering
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [1:0]  kind;
    logic        rw;
    logic [1:0]  size;
    logic        xfer_begin;
    logic        xfer_ack;
    logic        xfer_err_ack;
    logic        slave_nocache;
    logic        burst_refuse;
    logic        read_latch_clk;
    logic [1:0]  snoop_sel;
    logic        bus_grant;
    logic        bus_owned;
    logic        cache_off;
    logic        xlate_off;
    logic [2:0]  irq_level;
    logic        auto_vector_req;
  } sbi_pin_in_t;
  // Levels driven to the pins while enabled
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [1:0]  kind;
    logic        rw;
    logic [1:0]  size;
    logic        xfer_begin;
    logic        bus_owned;
  } sbi_pin_out_t;
  // Transfer request from the core
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0]  kind;
    logic        rw;
    logic [1:0]  size;
    logic        lock;
    logic        lock_last;
  } sbi_req_t;
  // Per-beat answer to the core
  typedef struct packed {
    logic [31:0] rdata;
    logic [3:0]  lanes;
    logic        err;
    logic        nocache;
    logic        burst_refused;
    logic        auto_vec;
    logic        last;
  } sbi_ans_t;
  // Alternate master access seen on the bus
  typedef struct packed {
    logic [31:0] addr;
    logic        rw;
    logic [1:0]  size;
    logic [1:0]  op;
  } sbi_snoop_t;
  typedef enum logic [1:0] {S_IDLE, S_ARB, S_START, S_WAIT} sbi_state_t;
endpackage
`default_nettype wire

// [sbi_regs.svh]
/*
  Constants of the system bus interface: transfer kinds, sizes,
  snoop selections, burst length, lane masks and interrupt level.
  Assumes inclusion by bare name from the core and the bench.
*/
`ifndef SBI_REGS_SVH
`define SBI_REGS_SVH
// Transfer kind codes
`define SBI_KIND_NORMAL 2'h0
`define SBI_KIND_MOVE   2'h1
`define SBI_KIND_ALT    2'h2
`define SBI_KIND_ACK    2'h3
// Transfer size codes
`define SBI_SIZE_LONG   2'h0
`define SBI_SIZE_BYTE   2'h1
`define SBI_SIZE_WORD   2'h2
`define SBI_SIZE_LINE   2'h3
// Snoop selection meaning no snoop
`define SBI_SNOOP_NONE  2'h0
// Index of the last beat of a line burst
`define SBI_LAST_BEAT   2'h3
// Lane masks
`define SBI_LANES_ALL   4'hF
`define SBI_LANES_NONE  4'h0
`define SBI_LANE_ONE    4'h1
`define SBI_LANE_TWO    4'h3
// Zero interrupt level
`define SBI_IRQ_NONE    3'h0
`endif

// [test_cpu_system_bus_interface.sv]
/*
  Self-checking bench of the system bus interface with a far-side
  model of arbiter, slave and alternate master.
  Assumes sbi_regs.svh on the include path and a 200 MHz sys_clk.
*/
`include "sbi_regs.svh"
`default_nettype none
module test_cpu_system_bus_interface
  import sbi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] RD_BASE  = 32'h5A00_0000;
  localparam logic [31:0] ALT_ADDR = 32'h00C0_FFE0;
  logic sys_clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_ready;
  logic ans_valid, snoop_valid, snoop_intervene = 1'b0;
  logic soft_reset = 1'b0, caches_off, mux_mode, bus_req, lock;
  logic rmw_last, xfer_active, mem_suppress, reset_out;
  logic latch_mode, irq_waiting;
  logic addr_oe_n, data_oe_n, attr_oe_n, begin_oe_n, owned_oe_n;
  logic err_on = 1'b0, refuse_on = 1'b0, nc_on = 1'b0;
  logic cache_off = 1'b0, alt_go = 1'b0;
  logic [1:0]   alt_kind = 2'h0, alt_sel = 2'h0;
  sbi_req_t     req = '0;
  sbi_ans_t     ans;
  sbi_snoop_t   snoop;
  sbi_pin_in_t  pin_in;
  sbi_pin_out_t pin_out;
  int n_mismatch = 0, comparisons = 0;
  // 5 ns period
  always #2.5 sys_clk = ~sys_clk;
  sbi_core sbi_core_i (.sys_clk, .rstn, .req_valid, .req_ready, .req,
    .ans_valid, .ans, .snoop_valid, .snoop, .snoop_intervene,
    .soft_reset, .caches_off, .mux_mode, .latch_mode, .irq_waiting,
    .pin_in, .pin_out, .addr_oe_n, .data_oe_n, .attr_oe_n, .begin_oe_n,
    .owned_oe_n, .bus_req, .lock, .rmw_last, .xfer_active, .mem_suppress,
    .reset_out);
  sbi_far_model #(.RD_BASE(RD_BASE), .ALT_ADDR(ALT_ADDR))
    sbi_far_model_i (.sys_clk, .rstn, .bus_req, .xfer_active, .pin_out,
    .addr_oe_n, .data_oe_n, .attr_oe_n, .begin_oe_n, .owned_oe_n,
    .err_on, .refuse_on, .nc_on, .cache_off, .alt_go, .alt_kind,
    .alt_sel, .pin_in);
  // Verdict and end of run
  task automatic summarize;
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Reset with a strap level on the cache disable pin
  task automatic t_reset(input logic strap);
    @(posedge sys_clk);
    rstn <= 1'b0;
    cache_off <= strap;
    // Strap needs the model flop plus the pin filter before release
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    check({xfer_active, bus_req, addr_oe_n, owned_oe_n}, 4'h3);
    @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(negedge sys_clk);
    check(mux_mode, strap);
    check({latch_mode, irq_waiting}, 2'b00);
    check(caches_off, strap);
    @(posedge sys_clk);
    cache_off <= 1'b0;
    repeat (8) @(negedge sys_clk);
    check(caches_off, 1'b0);
  endtask
  // One mastered transfer, checked beat by beat
  task automatic run(input logic [31:0] a, input logic [1:0] k, s,
    input logic r, lk, ll, ee, enc, input int nb);
    int beats, nbeg;
    logic done;
    logic [3:0] ln;
    logic [31:0] ea;
    beats = 0;
    nbeg = 0;
    done = 1'b0;
    ea = (k == `SBI_KIND_ACK) ? 32'h0 : a;
    case (s)
      `SBI_SIZE_BYTE: ln = 4'h1 << a[1:0];
      `SBI_SIZE_WORD: ln = a[1] ? 4'hC : 4'h3;
      default:        ln = `SBI_LANES_ALL;
    endcase
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req <= '{a, ~a, k, r, s, lk, ll};
    for (int n = 0; n < 300 && !done; n++)
    begin
      @(negedge sys_clk);
      if (req_valid && req_ready)
      begin
        @(posedge sys_clk);
        req_valid <= 1'b0;
      end
      else
      begin
        if (xfer_active)
          check({pin_out.addr, pin_out.kind, pin_out.rw, pin_out.size,
            lock, rmw_last, addr_oe_n, attr_oe_n},
            {ea, k, r, s, lk, ll, 2'b00});
        if (xfer_active && !pin_out.xfer_begin)
          check({owned_oe_n, pin_out.bus_owned}, 2'b01);
        if (xfer_active && !pin_out.xfer_begin && !r)
          check({data_oe_n, pin_out.data}, {1'b0, ~a});
        if (pin_out.xfer_begin && !begin_oe_n)
        begin
          nbeg++;
          check({xfer_active, bus_req}, 2'b10);
        end
        if (ans_valid)
        begin
          beats++;
          check({ans.err, ans.nocache, ans.lanes, ans.last},
            {ee, enc, ln, beats == nb});
          check({ans.burst_refused, ans.auto_vec},
            {s == `SBI_SIZE_LINE && refuse_on, 1'b0});
          if (r && !ee)
            check(ans.rdata, RD_BASE + 32'(beats - 1));
          done = ans.last;
        end
      end
    end
    if (!done)
    begin
      n_mismatch++;
      summarize();
    end
    check(nbeg, 1);
    check(beats, nb);
    @(negedge sys_clk);
    check({xfer_active, owned_oe_n}, 2'b01);
  endtask
  // Every kind code, byte lanes at every offset, word and top address
  task automatic t_kinds;
    for (int i = 0; i < 4; i++)
      run(32'h0000_1010 + i, 2'(i), `SBI_SIZE_BYTE, 0, 0, 0, 0, 0, 1);
    run(32'h0000_2002, `SBI_KIND_MOVE, `SBI_SIZE_WORD, 0, 0, 0, 0, 0, 1);
    run(32'hFFFF_FFFC, `SBI_KIND_NORMAL, `SBI_SIZE_LONG, 1, 0, 0, 0, 0, 1);
  endtask
  // Line burst in full, then cut short by the slave
  task automatic t_burst;
    run(32'h0000_4000, `SBI_KIND_NORMAL, `SBI_SIZE_LINE, 1, 0, 0, 0, 0, 4);
    @(posedge sys_clk);
    refuse_on <= 1'b1;
    run(32'h0000_4010, `SBI_KIND_NORMAL, `SBI_SIZE_LINE, 1, 0, 0, 0, 0, 1);
    @(posedge sys_clk);
    refuse_on <= 1'b0;
    err_on <= 1'b1;
    run(32'h0000_4020, `SBI_KIND_NORMAL, `SBI_SIZE_LINE, 1, 0, 0, 1, 0, 1);
    @(posedge sys_clk);
    err_on <= 1'b0;
  endtask
  // No-cache from the slave and from the cache disable pin
  task automatic t_nocache;
    @(posedge sys_clk);
    nc_on <= 1'b1;
    run(32'h0000_5000, `SBI_KIND_NORMAL, `SBI_SIZE_LONG, 1, 0, 0, 0, 1, 1);
    @(posedge sys_clk);
    nc_on <= 1'b0;
    cache_off <= 1'b1;
    repeat (6) @(posedge sys_clk);
    run(32'h0000_5004, `SBI_KIND_NORMAL, `SBI_SIZE_LONG, 1, 0, 0, 0, 1, 1);
    @(posedge sys_clk);
    cache_off <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask
  // Locked pair: lock alone, then lock with end marker
  task automatic t_lock;
    run(32'h0000_6000, `SBI_KIND_NORMAL, `SBI_SIZE_LONG, 1, 1, 0, 0, 0, 1);
    run(32'h0000_6000, `SBI_KIND_NORMAL, `SBI_SIZE_LONG, 0, 1, 1, 0, 0, 1);
  endtask
  // One alternate master access, snooped or not
  task automatic alt(input logic [1:0] k, sel, input logic iv, ex);
    int ns, nm;
    ns = 0;
    nm = 0;
    @(posedge sys_clk);
    alt_kind <= k;
    alt_sel <= sel;
    snoop_intervene <= iv;
    alt_go <= 1'b1;
    repeat (24)
    begin
      @(negedge sys_clk);
      if (snoop_valid)
      begin
        ns++;
        check({snoop.addr, snoop.op}, {ALT_ADDR, sel});
      end
      if (mem_suppress)
        nm++;
    end
    @(posedge sys_clk);
    alt_go <= 1'b0;
    snoop_intervene <= 1'b0;
    check(ns, ex);
    check(nm != 0, ex && iv);
    repeat (6) @(negedge sys_clk);
    check(mem_suppress, 1'b0);
  endtask
  task automatic t_snoop;
    alt(`SBI_KIND_NORMAL, 2'h1, 1, 1);
    alt(`SBI_KIND_MOVE, 2'h2, 0, 1);
    alt(`SBI_KIND_ALT, 2'h1, 1, 0);
    alt(`SBI_KIND_ACK, 2'h2, 1, 0);
    alt(`SBI_KIND_NORMAL, `SBI_SNOOP_NONE, 1, 0);
  endtask
  // Software reset drives the reset output one cycle later
  task automatic t_soft;
    @(posedge sys_clk);
    soft_reset <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check(reset_out, 1'b1);
    @(posedge sys_clk);
    soft_reset <= 1'b0;
    repeat (2) @(negedge sys_clk);
    check(reset_out, 1'b0);
  endtask
  // Main sequence; mux strap first, then normal mode for the rest
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset(1'b1);
    t_reset(1'b0);
    t_kinds();
    t_burst();
    t_nocache();
    t_lock();
    t_snoop();
    t_soft();
    summarize();
  end
endmodule
`default_nettype wire
